// *** hdl/uss_status_regs.sv ***
// Status registers one and two of the serial controller, behind an AXI4-Lite slave
// Behaviour
// - Transmit-free bit is 0 while holding register full, 1 when it can accept
// - Enabling transmitter sets free bit unless loaded; never set in echo or remote loop
// - Transmit-ready pin low while free bit set; held high in echo and remote loop
// - Receive-full bit sets on holding load, clears on read or disable; pin low while set, except held high in remote loop
// - Empty-or-change bit sets on line change while enabled, enabled modem change, or shift empty
// - Transmit-empty only after one character sent, also during fill; cleared by holding load
// - Reading status one clears empty-or-change bit; its pin is low while set, but shows line change only in echo and is held high in remote loop
// - Parity/escape flag shows parity error, or escape then non-sync non-escape in transparent
// - Parity/escape flag clears on next holding load, receiver disable or error clear
// - Overrun sets when holding register reloaded unread; clears on disable or error clear
// - Async framing flag sets when first stop bit missing; with zero char means break
// - Sync non-transparent framing flag sets on first sync, or first-second pair if double
// - Transparent: flag sets on initial sync, later on escape followed by first sync
// - Framing flag clears on disable; async on error clear, sync on status one read
// - Status one top bits mirror receiver-ready and data-mode inputs inverted
// - Status two low five bits read-only inverted copies of call, test, quality, standby, rate
// - Status two top three bits are writable change-interrupt enables
// - Enabled modem input changes show on empty-or-change bit, and on its pin except in remote loop
// - Error clear command clears parity, overrun and async framing flags, except one that a new error sets in the same cycle
`timescale 1ns/1ps
`include "uss_defs.svh"
module uss_status_regs (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [`USS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`USS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire uss_pkg::uss_cfg_type cfg,
    input wire uss_pkg::uss_tx_event_type txEvent,
    input wire uss_pkg::uss_rx_event_type rxEvent,
    input wire logic errorClearCmd,
    input wire logic rxHoldingRead,
    input wire logic [`USS_LINE_COUNT-1:0] lineInN,
    output logic txReadyN,
    output logic rxReadyN,
    output logic emptyChangeN
);
    logic [`USS_LINE_COUNT-1:0] lineMeta_r;
    logic [`USS_LINE_COUNT-1:0] lineSync_r;
    logic [`USS_LINE_COUNT-1:0] linePrev_r;
    logic [`USS_LINE_COUNT-1:0] lineDiff;
    logic [2:0] irqEn_r;
    logic txFree_r;
    logic txHoldFull_r;
    logic txOnPrev_r;
    logic sentOne_r;
    logic txEmpty_r;
    logic lineChange_r;
    logic rxFull_r;
    logic parityEscape_r;
    logic overrun_r;
    logic framingSync_r;
    logic escapePrev_r;
    logic firstSyncPrev_r;
    logic synced_r;
    logic loopLike;
    logic anyOn;
    logic lineEvent;
    logic status1Read;
    logic [7:0] status1;
    logic [7:0] status2;
    logic parityEscape_nxt;
    logic framingSet;
    logic initialSync;
    logic [`USS_ADDR_W-1:0] awAddr_r;
    logic awHeld_r;
    logic [7:0] wByte_r;
    logic wLane_r;
    logic wHeld_r;
    logic doWrite;
    logic arTake;

    function automatic logic is_mapped(input logic [`USS_ADDR_W-1:0] a);
        is_mapped = (a == `USS_OFS_RX_TX_STATUS) || (a == `USS_OFS_MODEM_STATUS);
    endfunction

    // Modem inputs: two-stage synchroniser, then a history stage for change detection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lineMeta_r <= '1;
            lineSync_r <= '1;
            linePrev_r <= '1;
        end else begin
            lineMeta_r <= lineInN;
            lineSync_r <= lineMeta_r;
            linePrev_r <= lineSync_r;
        end
    end

    assign lineDiff = lineSync_r ^ linePrev_r;
    assign loopLike = (cfg.subMode == uss_pkg::USS_ECHO) || (cfg.subMode == uss_pkg::USS_REMOTE_LOOP);
    assign anyOn = cfg.transmitterOnBit | cfg.receiverOnBit;
    assign lineEvent = (anyOn & (lineDiff[`USS_LINE_RR] | lineDiff[`USS_LINE_DM]))
        | (irqEn_r[0] & lineDiff[`USS_LINE_CALL])
        | (irqEn_r[1] & lineDiff[`USS_LINE_TEST])
        | (irqEn_r[2] & (lineDiff[`USS_LINE_QUALITY] | lineDiff[`USS_LINE_STANDBY]
            | lineDiff[`USS_LINE_RATE]));

    assign arTake = s_axi_arvalid & s_axi_arready;
    assign status1Read = arTake && (s_axi_araddr == `USS_OFS_RX_TX_STATUS);
    assign doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;

    // Transmit holding register state and free bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txHoldFull_r <= 1'b0;
            txFree_r <= 1'b0;
            txOnPrev_r <= 1'b0;
        end else begin
            txOnPrev_r <= cfg.transmitterOnBit;
            if (txEvent.holdLoad) begin
                txHoldFull_r <= 1'b1;
            end else if (txEvent.holdXfer) begin
                txHoldFull_r <= 1'b0;
            end
            if (loopLike) begin
                txFree_r <= 1'b0;
            end else if (txEvent.holdLoad) begin
                txFree_r <= 1'b0;
            end else if (cfg.transmitterOnBit && !txOnPrev_r && !txHoldFull_r) begin
                txFree_r <= 1'b1;
            end else if (txEvent.holdXfer) begin
                txFree_r <= 1'b1;
            end
        end
    end

    // Transmit-empty and line-change halves of the combined bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sentOne_r <= 1'b0;
            txEmpty_r <= 1'b0;
            lineChange_r <= 1'b0;
        end else begin
            if (txEvent.shiftDone) begin
                sentOne_r <= 1'b1;
            end
            if (txEvent.shiftDone && !txHoldFull_r && !txEvent.holdLoad) begin
                txEmpty_r <= 1'b1;
            end else if (txEvent.holdLoad || status1Read) begin
                txEmpty_r <= 1'b0;
            end
            if (lineEvent) begin
                lineChange_r <= 1'b1;
            end else if (status1Read) begin
                lineChange_r <= 1'b0;
            end
        end
    end

    // Receive holding full and overrun
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxFull_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (rxEvent.load) begin
                rxFull_r <= 1'b1;
            end else if (rxHoldingRead || !cfg.receiverOnBit) begin
                rxFull_r <= 1'b0;
            end
            if (rxEvent.load && rxFull_r && !rxHoldingRead) begin
                overrun_r <= 1'b1;
            end else if (errorClearCmd || !cfg.receiverOnBit) begin
                overrun_r <= 1'b0;
            end
        end
    end

    // Character history for escape and sync pair detection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            escapePrev_r <= 1'b0;
            firstSyncPrev_r <= 1'b0;
        end else if (!cfg.receiverOnBit) begin
            escapePrev_r <= 1'b0;
            firstSyncPrev_r <= 1'b0;
        end else if (rxEvent.charValid) begin
            // The second escape of a pair is data, not a new escape
            escapePrev_r <= (rxEvent.char == cfg.escapeChar) && !escapePrev_r;
            firstSyncPrev_r <= rxEvent.char == cfg.firstSyncChar;
        end
    end

    always_comb begin
        parityEscape_nxt = 1'b0;
        if (cfg.parityCheckOn) begin
            parityEscape_nxt = rxEvent.parityBad;
        end else if (cfg.syncMode && cfg.transparentSel) begin
            parityEscape_nxt = escapePrev_r && (rxEvent.char != cfg.firstSyncChar)
                && (rxEvent.char != cfg.escapeChar);
        end
    end

    always_comb begin
        initialSync = cfg.doubleSync ? (firstSyncPrev_r && rxEvent.char == cfg.secondSyncChar)
            : (rxEvent.char == cfg.firstSyncChar);
        framingSet = 1'b0;
        if (!cfg.syncMode) begin
            framingSet = rxEvent.load && rxEvent.stopMissing;
        end else if (!cfg.transparentSel) begin
            framingSet = rxEvent.charValid && initialSync;
        end else if (!synced_r) begin
            framingSet = rxEvent.charValid && initialSync;
        end else begin
            framingSet = rxEvent.charValid && escapePrev_r && rxEvent.char == cfg.firstSyncChar;
        end
    end

    // Parity/escape and framing/sync flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            parityEscape_r <= 1'b0;
            framingSync_r <= 1'b0;
            synced_r <= 1'b0;
        end else begin
            if (rxEvent.load && parityEscape_nxt) begin
                parityEscape_r <= 1'b1;
            end else if (rxEvent.load || errorClearCmd || !cfg.receiverOnBit) begin
                parityEscape_r <= 1'b0;
            end
            if (!cfg.receiverOnBit) begin
                synced_r <= 1'b0;
            end else if (cfg.syncMode && rxEvent.charValid && initialSync) begin
                synced_r <= 1'b1;
            end
            if (framingSet && cfg.receiverOnBit) begin
                framingSync_r <= 1'b1;
            end else if (!cfg.receiverOnBit) begin
                framingSync_r <= 1'b0;
            end else if (!cfg.syncMode && errorClearCmd) begin
                framingSync_r <= 1'b0;
            end else if (cfg.syncMode && status1Read) begin
                framingSync_r <= 1'b0;
            end
        end
    end

    // Output pins, all registered
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txReadyN <= 1'b1;
            rxReadyN <= 1'b1;
            emptyChangeN <= 1'b1;
        end else begin
            txReadyN <= !(txFree_r && !loopLike);
            rxReadyN <= !(rxFull_r && cfg.subMode != uss_pkg::USS_REMOTE_LOOP);
            if (cfg.subMode == uss_pkg::USS_REMOTE_LOOP) begin
                emptyChangeN <= 1'b1;
            end else if (cfg.subMode == uss_pkg::USS_ECHO) begin
                emptyChangeN <= !lineChange_r;
            end else begin
                emptyChangeN <= !(txEmpty_r || lineChange_r);
            end
        end
    end

    always_comb begin
        status1 = 8'h00;
        status1[`USS_SR1_TX_FREE] = txFree_r;
        status1[`USS_SR1_RX_FULL] = rxFull_r;
        status1[`USS_SR1_EMPTY_CHANGE] = (txEmpty_r && sentOne_r) || lineChange_r;
        status1[`USS_SR1_PARITY_ESCAPE] = parityEscape_r;
        status1[`USS_SR1_OVERRUN] = overrun_r;
        status1[`USS_SR1_FRAMING_SYNC] = framingSync_r;
        status1[`USS_SR1_RR_LINE] = !lineSync_r[`USS_LINE_RR];
        status1[`USS_SR1_DM_LINE] = !lineSync_r[`USS_LINE_DM];
        status2 = {irqEn_r, ~lineSync_r[`USS_LINE_RATE:`USS_LINE_CALL]};
    end

    // Change-interrupt enables, written through the bus
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqEn_r <= `USS_IRQ_EN_RESET;
        end else if (doWrite && wLane_r && awAddr_r == `USS_OFS_MODEM_STATUS) begin
            irqEn_r <= wByte_r[`USS_SR2_QUALITY_EN:`USS_SR2_CALL_EN];
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= '0;
            wByte_r <= 8'h00;
            wLane_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `USS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_r <= s_axi_awaddr;
                awHeld_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wByte_r <= s_axi_wdata[7:0];
                wLane_r <= s_axi_wstrb[0];
                wHeld_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(awAddr_r) ? `USS_RESP_OKAY : `USS_RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel: data one cycle after the address is taken
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `USS_RESP_OKAY;
        end else begin
            if (arTake) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `USS_RESP_OKAY : `USS_RESP_DECERR;
                if (s_axi_araddr == `USS_OFS_RX_TX_STATUS) begin
                    s_axi_rdata <= {24'h0, status1};
                end else if (s_axi_araddr == `USS_OFS_MODEM_STATUS) begin
                    s_axi_rdata <= {24'h0, status2};
                end else begin
                    s_axi_rdata <= 32'h0;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// *** hdl/uss_defs.svh ***
// Register offsets, field positions and reset values of the status block
`ifndef USS_DEFS_SVH
`define USS_DEFS_SVH
`define USS_ADDR_W 4
`define USS_OFS_RX_TX_STATUS 4'h0
`define USS_OFS_MODEM_STATUS 4'h4
`define USS_SR1_TX_FREE 0
`define USS_SR1_RX_FULL 1
`define USS_SR1_EMPTY_CHANGE 2
`define USS_SR1_PARITY_ESCAPE 3
`define USS_SR1_OVERRUN 4
`define USS_SR1_FRAMING_SYNC 5
`define USS_SR1_RR_LINE 6
`define USS_SR1_DM_LINE 7
`define USS_SR2_CALL_EN 5
`define USS_SR2_TEST_EN 6
`define USS_SR2_QUALITY_EN 7
`define USS_LINE_CALL 0
`define USS_LINE_TEST 1
`define USS_LINE_QUALITY 2
`define USS_LINE_STANDBY 3
`define USS_LINE_RATE 4
`define USS_LINE_RR 5
`define USS_LINE_DM 6
`define USS_LINE_COUNT 7
`define USS_IRQ_EN_RESET 3'h0
`define USS_RESP_OKAY 2'h0
`define USS_RESP_DECERR 2'h3
`endif

// *** hdl/uss_pkg.sv ***
// Types shared by the status block and its neighbours
package uss_pkg;
    typedef enum logic [1:0] {
        USS_NORMAL,
        USS_ECHO,
        USS_LOCAL_LOOP,
        USS_REMOTE_LOOP
    } uss_submode_type;

    typedef struct packed {
        logic transmitterOnBit;
        logic receiverOnBit;
        logic syncMode;
        logic parityCheckOn;
        logic transparentSel;
        logic doubleSync;
        uss_submode_type subMode;
        logic [7:0] firstSyncChar;
        logic [7:0] secondSyncChar;
        logic [7:0] escapeChar;
    } uss_cfg_type;

    typedef struct packed {
        logic holdLoad;
        logic holdXfer;
        logic shiftDone;
    } uss_tx_event_type;

    typedef struct packed {
        logic charValid;
        logic load;
        logic [7:0] char;
        logic parityBad;
        logic stopMissing;
    } uss_rx_event_type;
endpackage

// *** bench/uss_modem_model.sv ***
// Data set model driving the active-low modem status lines
`timescale 1ns/1ps
`include "uss_defs.svh"
module uss_modem_model (
    input logic linkClk,
    input logic [`USS_LINE_COUNT-1:0] wantN,
    output logic [`USS_LINE_COUNT-1:0] lineInN
);
    initial lineInN = '1;
    // Lines move only on the data set's own clock, never in step with the block
    always @(posedge linkClk) begin
        lineInN <= wantN;
    end
endmodule

// *** bench/uss_status_monitor.sv ***
// Port-level assertions for the status register block
`timescale 1ns/1ps
`include "uss_defs.svh"
module uss_status_monitor (
    input logic ref_clk,
    input logic srst,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic [`USS_ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input uss_pkg::uss_cfg_type cfg,
    input uss_pkg::uss_tx_event_type txEvent,
    input uss_pkg::uss_rx_event_type rxEvent,
    input logic [`USS_LINE_COUNT-1:0] lineInN,
    input logic txReadyN,
    input logic rxReadyN,
    input logic emptyChangeN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    read_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    unmapped_read_a:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3] |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rx_full_pin_a:
        assert property (rxEvent.load && cfg.subMode == uss_pkg::USS_NORMAL ##1 cfg.subMode == uss_pkg::USS_NORMAL |-> ##1 !rxReadyN)
        else $error("receive pin late");
    tx_busy_pin_a:
        assert property (txEvent.holdLoad && !txEvent.holdXfer |-> ##2 txReadyN)
        else $error("transmit pin low while busy");
    remote_pins_a:
        assert property (cfg.subMode == uss_pkg::USS_REMOTE_LOOP [*2] |-> txReadyN && rxReadyN && emptyChangeN)
        else $error("pins not held in remote loop");
    dm_change_a:
        assert property ($changed(lineInN[`USS_LINE_DM]) && cfg.transmitterOnBit && cfg.subMode == uss_pkg::USS_NORMAL
            |-> ##[3:4] !emptyChangeN)
        else $error("line change not signalled");
    cover property (rxEvent.load);
    cover property (s_axi_bvalid);
    cover property (cfg.subMode == uss_pkg::USS_ECHO);
endmodule
bind uss_status_regs uss_status_monitor i_mon (.ref_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cfg, .txEvent, .rxEvent, .lineInN, .txReadyN, .rxReadyN, .emptyChangeN);

// *** bench/uss_status_regs_tb.sv ***
// Self-checking bench for the status register block
`timescale 1ns/1ps
`include "uss_defs.svh"
module uss_status_regs_tb;
    logic ref_clk = 1'h0, srst = 1'h1, linkClk = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txReadyN, rxReadyN, emptyChangeN;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    uss_pkg::uss_cfg_type cfg = '0;
    uss_pkg::uss_tx_event_type txEvent = '0;
    uss_pkg::uss_rx_event_type rxEvent = '0;
    logic errorClearCmd = 1'h0, rxHoldingRead = 1'h0;
    logic [6:0] wantN = 7'h7f, lineInN;
    logic [7:0] syncChar;
    logic [33:0] expQ[$];
    int bad_count = 0, checks = 0, seed = 32'h9f88;
    always #5 ref_clk = ~ref_clk;
    initial begin
        #3.3;
        forever #80 linkClk = ~linkClk;
    end
    uss_status_regs i_dut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg, .txEvent, .rxEvent,
        .errorClearCmd, .rxHoldingRead, .lineInN, .txReadyN, .rxReadyN, .emptyChangeN);
    uss_modem_model i_modem (.linkClk, .wantN, .lineInN);
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, 32'h0});
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [1:0] r, input logic [7:0] v);
        expQ.push_back({r, 24'h0, v});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask
    task automatic txp(input logic [2:0] e);
        @(posedge ref_clk);
        txEvent <= e;
        @(posedge ref_clk);
        txEvent <= '0;
    endtask
    task automatic rxp(input logic [1:0] vl, input logic [7:0] c, input logic [1:0] e);
        @(posedge ref_clk);
        rxEvent <= {vl, c, e};
        @(posedge ref_clk);
        rxEvent <= '0;
    endtask
    // Bit 1 error clear, bit 0 holding register read
    task automatic cmd(input logic [1:0] c);
        @(posedge ref_clk);
        {errorClearCmd, rxHoldingRead} <= c;
        @(posedge ref_clk);
        {errorClearCmd, rxHoldingRead} <= 2'h0;
    endtask
    task automatic done(input string n);
        $display("test %s done", n);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Scoreboard: each answer on the bus takes the oldest note
    always @(posedge ref_clk) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expQ.pop_front());
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        tick(20);
        srst <= 1'h0;
        rd(4'h0, 2'h0, 8'h00);
        rd(4'h4, 2'h0, 8'h00);
        done("reset");
        cfg.transmitterOnBit <= 1'h1;
        rd(4'h0, 2'h0, 8'h01);
        chk(txReadyN, 1'h0);
        txp(3'h4);
        rd(4'h0, 2'h0, 8'h00);
        chk(txReadyN, 1'h1);
        txp(3'h2);
        txp(3'h1);
        tick(2);
        chk(emptyChangeN, 1'h0);
        rd(4'h0, 2'h0, 8'h05);
        rd(4'h0, 2'h0, 8'h01);
        txp(3'h1);
        txp(3'h4);
        rd(4'h0, 2'h0, 8'h00);
        txp(3'h2);
        done("transmit");
        cfg.receiverOnBit <= 1'h1;
        rxp(2'h1, 8'h41, 2'h0);
        rd(4'h0, 2'h0, 8'h03);
        chk(rxReadyN, 1'h0);
        rxp(2'h1, 8'h42, 2'h0);
        rd(4'h0, 2'h0, 8'h13);
        cmd(2'h1);
        rd(4'h0, 2'h0, 8'h11);
        cmd(2'h2);
        rd(4'h0, 2'h0, 8'h01);
        cfg.parityCheckOn <= 1'h1;
        rxp(2'h1, 8'h43, 2'h2);
        rd(4'h0, 2'h0, 8'h0b);
        cmd(2'h1);
        rxp(2'h1, 8'h44, 2'h0);
        rd(4'h0, 2'h0, 8'h03);
        cmd(2'h1);
        rxp(2'h1, 8'h00, 2'h1);
        rd(4'h0, 2'h0, 8'h23);
        cmd(2'h3);
        rd(4'h0, 2'h0, 8'h01);
        rxp(2'h1, 8'h45, 2'h0);
        cfg.receiverOnBit <= 1'h0;
        rd(4'h0, 2'h0, 8'h01);
        done("receive");
        syncChar = 8'($random(seed));
        cfg <= {2'h3, 2'h2, 1'h0, 1'h0, uss_pkg::USS_NORMAL, syncChar, ~syncChar, 8'h10};
        rxp(2'h2, syncChar, 2'h0);
        rd(4'h0, 2'h0, 8'h21);
        rd(4'h0, 2'h0, 8'h01);
        cfg.doubleSync <= 1'h1;
        rxp(2'h2, syncChar, 2'h0);
        rd(4'h0, 2'h0, 8'h01);
        rxp(2'h2, ~syncChar, 2'h0);
        rd(4'h0, 2'h0, 8'h21);
        // Transparent mode: escape differs from both sync characters whatever the seed gives
        cfg <= {2'h2, 2'h2, 1'h1, 1'h0, uss_pkg::USS_NORMAL, syncChar, ~syncChar, syncChar ^ 8'h80};
        tick(2);
        cfg.receiverOnBit <= 1'h1;
        rxp(2'h2, syncChar, 2'h0);
        rd(4'h0, 2'h0, 8'h21);
        rxp(2'h2, syncChar ^ 8'h80, 2'h0);
        rxp(2'h2, syncChar, 2'h0);
        rd(4'h0, 2'h0, 8'h21);
        rxp(2'h2, syncChar ^ 8'h80, 2'h0);
        rxp(2'h3, ~syncChar, 2'h0);
        rd(4'h0, 2'h0, 8'h0b);
        cmd(2'h2);
        rd(4'h0, 2'h0, 8'h03);
        cmd(2'h1);
        cfg.syncMode <= 1'h0;
        done("sync");
        wr(4'h4, 32'hff, 2'h0);
        rd(4'h4, 2'h0, 8'he0);
        // Call and data-mode lines always fall, so both change paths are exercised
        wantN <= 7'($random(seed)) & 7'h3e;
        tick(40);
        chk(emptyChangeN, 1'h0);
        rd(4'h0, 2'h0, {~wantN[6:5], 6'h05});
        rd(4'h4, 2'h0, {3'h7, ~wantN[4:0]});
        wr(4'h4, 32'h0, 2'h0);
        wantN[0] <= ~wantN[0];
        tick(40);
        rd(4'h0, 2'h0, {~wantN[6:5], 6'h01});
        wr(4'h4, 32'h20, 2'h0);
        wantN[0] <= ~wantN[0];
        tick(40);
        rd(4'h0, 2'h0, {~wantN[6:5], 6'h05});
        done("modem");
        rd(4'h8, 2'h3, 8'h00);
        wr(4'hc, 32'h5a, 2'h3);
        wr(4'h0, 32'hff, 2'h0);
        rd(4'h4, 2'h0, {3'h1, ~wantN[4:0]});
        done("bus");
        cfg.subMode <= uss_pkg::USS_ECHO;
        tick(4);
        chk(txReadyN, 1'h1);
        rd(4'h0, 2'h0, {~wantN[6:5], 6'h00});
        cfg.subMode <= uss_pkg::USS_REMOTE_LOOP;
        tick(4);
        chk({txReadyN, rxReadyN, emptyChangeN}, 3'h7);
        done("loop modes");
        tally_and_finish();
    end
endmodule
